/* rtl/bvfpc_top.v */
// Bus-voltage fault limits and hardware pin settings register bank
// Functional notes
// - Block running below minimum bus voltage; code 0 no limit, 1-7 give 4.5-12.5 V.
// - Undervoltage fault latches when selector is 0, self-clears in bounds when 1.
// - Block running above maximum bus voltage; code 0 no limit, 1-7 give 20-35 V.
// - Overvoltage fault latches when selector is 0, self-clears in bounds when 1.
// - Retry limit code: 0 unlimited, 1-7 allow 2,3,5,7,10,15,20 attempts.
// - Bus voltage filter active when disable bit is 0, bypassed when 1.
// - Stopped: code 0 base feedback, codes 1 and 3 high, code 2 low.
// - Fault: code 0 holds last value, 1 high, 2 low, 3 base feedback.
// - Alarm output enabled only while alarm-enable bit is 1.
// - Brake request gives low-side brake with action bit 0, align brake with 1.
// - Align brake uses last angle with bit 0, configured align angle with 1.
// - Pin settings register sits at A4h and resets to all zeros.
// - Brake source: codes 0,3 pin, 1 forced brake, 2 forced no brake.
// - Retries beyond the limit stop retrying and latch the fault indicator.
`default_nettype none
`include "bvfpc_map.vh"

module bvfpc_top
(
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [31:0] i_reg_wdata,
    output reg [31:0] o_reg_rdata,
    input wire [15:0] i_vbus_mv,
    input wire i_vbus_valid,
    input wire i_fault_clear,
    input wire i_retry_attempt,
    input wire i_motor_stopped,
    input wire i_other_fault,
    input wire i_speed_fb_base,
    input wire i_alarm_req,
    input wire i_brake_pin,
    output reg o_motor_run_allow,
    output reg o_undervoltage_fault,
    output reg o_overvoltage_fault,
    output wire o_fault_indicator_n,
    output wire o_retry_allowed,
    output reg o_speed_feedback_output,
    output reg o_alarm_out,
    output reg o_brake_lowside,
    output reg o_brake_align,
    output reg o_align_use_cfg_angle,
    output reg [1:0] o_speed_mode,
    output reg [15:0] o_vbus_used_mv
);

    reg [31:0] pin_r;
    reg [31:0] flt2_r;
    reg [17:0] filt_r;
    reg [17:0] filt_nxt;
    reg [15:0] vcmp;
    reg [15:0] min_thr;
    reg [15:0] max_thr;
    reg uv_nxt;
    reg ov_nxt;
    reg fb_last_r;
    reg fb_nxt;
    reg brake_req;
    reg [2:0] brk_sync_r;
    reg brk_pin_r;
    wire [2:0] min_code;
    wire [2:0] max_code;
    wire uv_hit;
    wire ov_hit;
    wire in_fault;
    wire [4:0] retry_count;
    wire retry_exhausted;

    assign min_code = flt2_r[`BVFPC_MINV_HI:`BVFPC_MINV_LO];
    assign max_code = flt2_r[`BVFPC_MAXV_HI:`BVFPC_MAXV_LO];

    // -----------------------------------------------------------------
    // Register write port
    // -----------------------------------------------------------------
    // Unlisted offsets take no write so reserved space stays untouched
    always @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_r <= `BVFPC_PIN_RST;
            flt2_r <= `BVFPC_FLT2_RST;
        end
        else if (i_reg_wr)
        begin
            if (i_reg_addr == `BVFPC_PIN_OFS)
                pin_r <= i_reg_wdata & `BVFPC_PIN_MASK;
            else if (i_reg_addr == `BVFPC_FLT2_OFS)
                flt2_r <= i_reg_wdata & `BVFPC_FLT2_MASK;
        end
    end

    // -----------------------------------------------------------------
    // Register read port, one cycle latency
    // -----------------------------------------------------------------
    always @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_reg_rdata <= 32'h0000_0000;
        else if (i_reg_rd)
        begin
            case (i_reg_addr)
                `BVFPC_PIN_OFS: o_reg_rdata <= pin_r;
                `BVFPC_FLT2_OFS: o_reg_rdata <= flt2_r;
                `BVFPC_STAT_OFS: o_reg_rdata <= {7'h00, o_vbus_used_mv, 1'b0, retry_count,
                                                  retry_exhausted, o_overvoltage_fault,
                                                  o_undervoltage_fault};
                default: o_reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Threshold lookup
    // -----------------------------------------------------------------
    always @*
    begin
        case (min_code)
            3'h1: min_thr = `BVFPC_MIN_1;
            3'h2: min_thr = `BVFPC_MIN_2;
            3'h3: min_thr = `BVFPC_MIN_3;
            3'h4: min_thr = `BVFPC_MIN_4;
            3'h5: min_thr = `BVFPC_MIN_5;
            3'h6: min_thr = `BVFPC_MIN_6;
            3'h7: min_thr = `BVFPC_MIN_7;
            default: min_thr = 16'h0000;
        endcase
        case (max_code)
            3'h1: max_thr = `BVFPC_MAX_1;
            3'h2: max_thr = `BVFPC_MAX_2;
            3'h3: max_thr = `BVFPC_MAX_3;
            3'h4: max_thr = `BVFPC_MAX_4;
            3'h5: max_thr = `BVFPC_MAX_5;
            3'h6: max_thr = `BVFPC_MAX_6;
            3'h7: max_thr = `BVFPC_MAX_7;
            default: max_thr = 16'hffff;
        endcase
    end

    // -----------------------------------------------------------------
    // Bus voltage filter: quarter-weight running average
    // -----------------------------------------------------------------
    always @*
    begin
        filt_nxt = ((filt_r << 1) + filt_r + {2'b00, i_vbus_mv}) >> 2;
        if (pin_r[`BVFPC_FILT_OFF_BIT])
            vcmp = i_vbus_mv;
        else
            vcmp = filt_nxt[15:0];
    end

    // Filter keeps tracking while bypassed so re-enabling does not jump
    always @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            filt_r <= 18'h00000;
            o_vbus_used_mv <= 16'h0000;
        end
        else if (i_vbus_valid)
        begin
            filt_r <= filt_nxt;
            o_vbus_used_mv <= vcmp;
        end
    end

    // -----------------------------------------------------------------
    // Limit comparison, once per control cycle
    // -----------------------------------------------------------------
    assign uv_hit = i_vbus_valid && (min_code != 3'h0) && (vcmp < min_thr);
    assign ov_hit = i_vbus_valid && (max_code != 3'h0) && (vcmp > max_thr);

    // Set wins over clear; auto recovery only on an in-bounds sample
    always @*
    begin
        uv_nxt = o_undervoltage_fault;
        if (uv_hit)
            uv_nxt = 1'b1;
        else if (i_fault_clear)
            uv_nxt = 1'b0;
        else if (flt2_r[`BVFPC_UVREC_BIT] && i_vbus_valid)
            uv_nxt = 1'b0;
        ov_nxt = o_overvoltage_fault;
        if (ov_hit)
            ov_nxt = 1'b1;
        else if (i_fault_clear)
            ov_nxt = 1'b0;
        else if (flt2_r[`BVFPC_OVREC_BIT] && i_vbus_valid)
            ov_nxt = 1'b0;
    end

    always @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_undervoltage_fault <= 1'b0;
            o_overvoltage_fault <= 1'b0;
            o_motor_run_allow <= 1'b0;
        end
        else
        begin
            o_undervoltage_fault <= uv_nxt;
            o_overvoltage_fault <= ov_nxt;
            o_motor_run_allow <= !uv_nxt && !ov_nxt && !retry_exhausted;
        end
    end

    // -----------------------------------------------------------------
    // Retry accounting
    // -----------------------------------------------------------------
    bvfpc_retry_ctr u_retry
    (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_code(flt2_r[`BVFPC_RETRY_HI:`BVFPC_RETRY_LO]),
        .i_retry(i_retry_attempt),
        .i_clear(i_fault_clear),
        .o_count(retry_count),
        .o_exhausted(retry_exhausted)
    );

    assign o_retry_allowed = !retry_exhausted;
    assign in_fault = o_undervoltage_fault || o_overvoltage_fault || i_other_fault || retry_exhausted;
    assign o_fault_indicator_n = !in_fault;

    // -----------------------------------------------------------------
    // Speed feedback output level
    // -----------------------------------------------------------------
    always @*
    begin
        fb_nxt = i_speed_fb_base;
        if (in_fault)
        begin
            case (pin_r[`BVFPC_FLTLV_HI:`BVFPC_FLTLV_LO])
                2'h0: fb_nxt = fb_last_r;
                2'h1: fb_nxt = 1'b1;
                2'h2: fb_nxt = 1'b0;
                default: fb_nxt = i_speed_fb_base;
            endcase
        end
        else if (i_motor_stopped)
        begin
            case (pin_r[`BVFPC_IDLE_HI:`BVFPC_IDLE_LO])
                2'h0: fb_nxt = i_speed_fb_base;
                2'h2: fb_nxt = 1'b0;
                default: fb_nxt = 1'b1;
            endcase
        end
    end

    // Base level seen while running is frozen while in fault or stopped
    always @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            fb_last_r <= 1'b0;
            o_speed_feedback_output <= 1'b0;
        end
        else
        begin
            if (!in_fault && !i_motor_stopped)
                fb_last_r <= i_speed_fb_base;
            o_speed_feedback_output <= fb_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Brake pin synchroniser: change counts once stages 2 and 3 agree
    // -----------------------------------------------------------------
    always @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            brk_sync_r <= 3'h0;
            brk_pin_r <= 1'b0;
        end
        else
        begin
            brk_sync_r <= {brk_sync_r[1:0], i_brake_pin};
            if (brk_sync_r[2] == brk_sync_r[1])
                brk_pin_r <= brk_sync_r[2];
        end
    end

    // -----------------------------------------------------------------
    // Brake source and action
    // -----------------------------------------------------------------
    always @*
    begin
        case (pin_r[`BVFPC_BRKIN_HI:`BVFPC_BRKIN_LO])
            2'h1: brake_req = 1'b1;
            2'h2: brake_req = 1'b0;
            default: brake_req = brk_pin_r;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_brake_lowside <= 1'b0;
            o_brake_align <= 1'b0;
            o_align_use_cfg_angle <= 1'b0;
            o_alarm_out <= 1'b0;
            o_speed_mode <= 2'h0;
        end
        else
        begin
            o_brake_lowside <= brake_req && !pin_r[`BVFPC_BRKMODE_BIT];
            o_brake_align <= brake_req && pin_r[`BVFPC_BRKMODE_BIT];
            o_align_use_cfg_angle <= pin_r[`BVFPC_ANGSEL_BIT];
            o_alarm_out <= i_alarm_req && pin_r[`BVFPC_ALARM_BIT];
            o_speed_mode <= pin_r[`BVFPC_SPDMODE_HI:`BVFPC_SPDMODE_LO];
        end
    end

endmodule
`default_nettype wire

/* rtl/bvfpc_map.vh */
// Register offsets, field positions, reset values and thresholds of the bus-voltage fault block
`ifndef BVFPC_MAP_VH
`define BVFPC_MAP_VH

// -----------------------------------------------------------------
// Register offsets (byte addresses on the configuration port)
// -----------------------------------------------------------------
`define BVFPC_PIN_OFS 8'ha4
`define BVFPC_FLT2_OFS 8'h92
`define BVFPC_STAT_OFS 8'h9e

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define BVFPC_PIN_RST 32'h0000_0000
`define BVFPC_FLT2_RST 32'h0000_0000

// -----------------------------------------------------------------
// Fault limits settings 2 field positions
// -----------------------------------------------------------------
`define BVFPC_MINV_HI 10
`define BVFPC_MINV_LO 8
`define BVFPC_UVREC_BIT 7
`define BVFPC_MAXV_HI 6
`define BVFPC_MAXV_LO 4
`define BVFPC_OVREC_BIT 3
`define BVFPC_RETRY_HI 2
`define BVFPC_RETRY_LO 0
`define BVFPC_FLT2_MASK 32'h0000_07ff

// -----------------------------------------------------------------
// Hardware pin settings field positions
// -----------------------------------------------------------------
`define BVFPC_FILT_OFF_BIT 27
`define BVFPC_IDLE_HI 10
`define BVFPC_IDLE_LO 9
`define BVFPC_FLTLV_HI 8
`define BVFPC_FLTLV_LO 7
`define BVFPC_ALARM_BIT 6
`define BVFPC_BRKMODE_BIT 5
`define BVFPC_ANGSEL_BIT 4
`define BVFPC_BRKIN_HI 3
`define BVFPC_BRKIN_LO 2
`define BVFPC_SPDMODE_HI 1
`define BVFPC_SPDMODE_LO 0
`define BVFPC_PIN_MASK 32'h0800_07ff

// -----------------------------------------------------------------
// Voltage thresholds in millivolts
// -----------------------------------------------------------------
`define BVFPC_MIN_1 16'h1194
`define BVFPC_MIN_2 16'h1388
`define BVFPC_MIN_3 16'h157c
`define BVFPC_MIN_4 16'h1770
`define BVFPC_MIN_5 16'h1d4c
`define BVFPC_MIN_6 16'h2710
`define BVFPC_MIN_7 16'h30d4
`define BVFPC_MAX_1 16'h4e20
`define BVFPC_MAX_2 16'h57e4
`define BVFPC_MAX_3 16'h61a8
`define BVFPC_MAX_4 16'h6b6c
`define BVFPC_MAX_5 16'h7530
`define BVFPC_MAX_6 16'h7ef4
`define BVFPC_MAX_7 16'h88b8

// -----------------------------------------------------------------
// Retry attempt limits per code
// -----------------------------------------------------------------
`define BVFPC_RTY_1 5'h02
`define BVFPC_RTY_2 5'h03
`define BVFPC_RTY_3 5'h05
`define BVFPC_RTY_4 5'h07
`define BVFPC_RTY_5 5'h0a
`define BVFPC_RTY_6 5'h0f
`define BVFPC_RTY_7 5'h14

`endif

/* rtl/bvfpc_retry_ctr.v */
// Automatic retry counter with limit lookup and latched exhaustion flag
`default_nettype none
`include "bvfpc_map.vh"

module bvfpc_retry_ctr
(
    input wire i_ref_clk,
    input wire i_reset_n,
    input wire [2:0] i_code,
    input wire i_retry,
    input wire i_clear,
    output reg [4:0] o_count,
    output reg o_exhausted
);

    reg [4:0] limit;
    reg [4:0] count_nxt;

    // -----------------------------------------------------------------
    // Limit lookup
    // -----------------------------------------------------------------
    always @*
    begin
        case (i_code)
            3'h1: limit = `BVFPC_RTY_1;
            3'h2: limit = `BVFPC_RTY_2;
            3'h3: limit = `BVFPC_RTY_3;
            3'h4: limit = `BVFPC_RTY_4;
            3'h5: limit = `BVFPC_RTY_5;
            3'h6: limit = `BVFPC_RTY_6;
            3'h7: limit = `BVFPC_RTY_7;
            default: limit = 5'h1f;
        endcase
        // Saturate so an unlimited run never wraps back to zero
        if (i_retry && (o_count != 5'h1f))
            count_nxt = o_count + 5'h01;
        else
            count_nxt = o_count;
    end

    // -----------------------------------------------------------------
    // Count and latch; a retry in the clear cycle still counts
    // -----------------------------------------------------------------
    always @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_count <= 5'h00;
            o_exhausted <= 1'b0;
        end
        else
        begin
            if (i_clear)
                o_count <= i_retry ? 5'h01 : 5'h00;
            else
                o_count <= count_nxt;
            if ((i_code != 3'h0) && (count_nxt > limit) && !i_clear)
                o_exhausted <= 1'b1;
            else if (i_clear)
                o_exhausted <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* sim/bvfpc_checker.sv */
// Concurrent checks on the bus-voltage fault and pin settings bank
`default_nettype none
`include "bvfpc_map.vh"

module bvfpc_checker
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [15:0] i_vbus_mv,
    input wire logic i_vbus_valid,
    input wire logic i_fault_clear,
    input wire logic i_retry_attempt,
    input wire logic o_motor_run_allow,
    input wire logic o_undervoltage_fault,
    input wire logic o_overvoltage_fault,
    input wire logic o_fault_indicator_n,
    input wire logic o_retry_allowed,
    input wire logic o_alarm_out,
    input wire logic o_brake_lowside,
    input wire logic o_brake_align,
    input wire logic [15:0] o_vbus_used_mv
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MIN_T [8] = '{16'h0000, `BVFPC_MIN_1, `BVFPC_MIN_2, `BVFPC_MIN_3, `BVFPC_MIN_4,
        `BVFPC_MIN_5, `BVFPC_MIN_6, `BVFPC_MIN_7};
    localparam logic [15:0] MAX_T [8] = '{16'h0000, `BVFPC_MAX_1, `BVFPC_MAX_2, `BVFPC_MAX_3, `BVFPC_MAX_4,
        `BVFPC_MAX_5, `BVFPC_MAX_6, `BVFPC_MAX_7};
    logic [31:0] pin_r;
    logic [31:0] flt2_r;
    wire logic [15:0] min_thr = MIN_T[flt2_r[10:8]];
    wire logic [15:0] max_thr = MAX_T[flt2_r[6:4]];

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ------------------------------------------------------------
    // Settings shadow
    // ------------------------------------------------------------
    // Mirrors writable bits from the strobes, so no peeking inside
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_r <= `BVFPC_PIN_RST;
            flt2_r <= `BVFPC_FLT2_RST;
        end
        else if (i_reg_wr && i_reg_addr == `BVFPC_PIN_OFS)
            pin_r <= i_reg_wdata & `BVFPC_PIN_MASK;
        else if (i_reg_wr && i_reg_addr == `BVFPC_FLT2_OFS)
            flt2_r <= i_reg_wdata & `BVFPC_FLT2_MASK;
    end

    // ------------------------------------------------------------
    // Sample sequences and properties
    // ------------------------------------------------------------
    // Only unfiltered samples are judged: the filtered value is not visible here
    sequence s_raw;
        i_vbus_valid && pin_r[27];
    endsequence
    sequence s_uv_hit;
        s_raw ##0 (flt2_r[10:8] != 3'h0 && i_vbus_mv < min_thr);
    endsequence
    sequence s_uv_ok;
        s_raw ##0 (flt2_r[7] && (flt2_r[10:8] == 3'h0 || i_vbus_mv >= min_thr));
    endsequence
    sequence s_ov_hit;
        s_raw ##0 (flt2_r[6:4] != 3'h0 && i_vbus_mv > max_thr);
    endsequence
    property p_uv_set;
        s_uv_hit |=> o_undervoltage_fault;
    endproperty
    a_uv_set: assert property (p_uv_set) else $error("undervoltage not flagged");
    property p_ov_set;
        s_ov_hit |=> o_overvoltage_fault;
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("overvoltage not flagged");
    property p_uv_auto;
        s_uv_ok |=> !o_undervoltage_fault;
    endproperty
    a_uv_auto: assert property (p_uv_auto) else $error("undervoltage did not self clear");
    property p_ov_latch;
        o_overvoltage_fault && !flt2_r[3] && !i_fault_clear |=> o_overvoltage_fault;
    endproperty
    a_ov_latch: assert property (p_ov_latch) else $error("latched overvoltage dropped");
    property p_run_block;
        o_undervoltage_fault || o_overvoltage_fault |-> !o_motor_run_allow;
    endproperty
    a_run_block: assert property (p_run_block) else $error("run allowed during bus fault");
    property p_ind;
        o_undervoltage_fault || o_overvoltage_fault || !o_retry_allowed |-> !o_fault_indicator_n;
    endproperty
    a_ind: assert property (p_ind) else $error("fault indicator not active");
    property p_exhaust;
        $fell(o_retry_allowed) |-> $past(i_retry_attempt) && flt2_r[2:0] != 3'h0;
    endproperty
    a_exhaust: assert property (p_exhaust) else $error("retries stopped without cause");
    property p_bypass;
        s_raw |=> o_vbus_used_mv == $past(i_vbus_mv);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypassed sample altered");
    property p_alarm;
        !pin_r[6] |=> !o_alarm_out;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm active while disabled");
    property p_no_brake;
        (pin_r[3:2] == 2'h2) [*6] |-> !o_brake_lowside && !o_brake_align;
    endproperty
    a_no_brake: assert property (p_no_brake) else $error("brake despite override off");
endmodule
`default_nettype wire

/* sim/bvfpc_top_tb.sv */
// Self-checking bench for the bus-voltage fault and pin settings bank
`default_nettype none
`include "bvfpc_map.vh"

module bvfpc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
    logic i_ref_clk = 0, i_reset_n = 0, i_reg_wr = 0, i_reg_rd = 0, i_vbus_valid = 0, i_fault_clear = 0;
    logic i_retry_attempt = 0, i_motor_stopped = 0, i_other_fault = 0, i_speed_fb_base = 0;
    logic i_alarm_req = 0, i_brake_pin = 0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0;
    logic [15:0] i_vbus_mv = 16'h0;
    wire [31:0] o_reg_rdata;
    wire o_motor_run_allow, o_undervoltage_fault, o_overvoltage_fault, o_fault_indicator_n, o_retry_allowed;
    wire o_speed_feedback_output, o_alarm_out, o_brake_lowside, o_brake_align, o_align_use_cfg_angle;
    wire [1:0] o_speed_mode;
    wire [15:0] o_vbus_used_mv;
    int fail_count = 0;
    int checked = 0;
    logic [15:0] mn [1:7] = '{`BVFPC_MIN_1, `BVFPC_MIN_2, `BVFPC_MIN_3, `BVFPC_MIN_4, `BVFPC_MIN_5,
        `BVFPC_MIN_6, `BVFPC_MIN_7};
    logic [15:0] mx [1:7] = '{`BVFPC_MAX_1, `BVFPC_MAX_2, `BVFPC_MAX_3, `BVFPC_MAX_4, `BVFPC_MAX_5,
        `BVFPC_MAX_6, `BVFPC_MAX_7};
    logic [4:0] lim [1:7] = '{`BVFPC_RTY_1, `BVFPC_RTY_2, `BVFPC_RTY_3, `BVFPC_RTY_4, `BVFPC_RTY_5,
        `BVFPC_RTY_6, `BVFPC_RTY_7};
    // Brake cases: pin level, source code, action bit, expected low-side, expected align
    logic [5:0] bt [7] = '{6'h22, 6'h25, 6'h3a, 6'h34, 6'h0d, 6'h0a, 6'h04};

    bvfpc_top bvfpc_top_i (.*);

    // Free-running 200 MHz clock
    initial
    begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    // ------------------------------------------------------------
    // Port access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_ref_clk);
        q = o_reg_rdata;
    endtask
    // One-cycle pulse of retry, clear or sample strobe; outputs read at the next falling edge
    task automatic hit(input logic [2:0] k, input logic [15:0] v);
        @(posedge i_ref_clk);
        i_vbus_mv <= v;
        {i_retry_attempt, i_fault_clear, i_vbus_valid} <= k;
        @(posedge i_ref_clk);
        {i_retry_attempt, i_fault_clear, i_vbus_valid} <= 3'h0;
        @(negedge i_ref_clk);
    endtask
    task automatic set(input logic [4:0] lv);
        @(posedge i_ref_clk);
        {i_motor_stopped, i_other_fault, i_speed_fb_base, i_alarm_req, i_brake_pin} <= lv;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask
    task automatic final_report;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] q;
        logic [2:0] k;
        logic [15:0] thr;
        repeat (6) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        rd(`BVFPC_PIN_OFS, q); `CHK(q, `BVFPC_PIN_RST)
        // Filter starts from zero, so two samples of 4000 mV give 1000 then 1750
        hit(3'h1, 16'h0fa0); `CHK(o_vbus_used_mv, 16'h03e8)
        hit(3'h1, 16'h0fa0); `CHK(o_vbus_used_mv, 16'h06d6)
        wr(`BVFPC_PIN_OFS, 32'hffff_ffff); rd(`BVFPC_PIN_OFS, q); `CHK(q, `BVFPC_PIN_MASK)
        // Reserved space is only ever read, never written
        rd(8'h50, q); `CHK(q, 32'h0)
        wr(`BVFPC_PIN_OFS, 32'h0800_0000);
        hit(3'h1, 16'h0fa0); `CHK(o_vbus_used_mv, 16'h0fa0)
        hit(3'h1, 16'h0000); `CHK(o_undervoltage_fault, 1'b0)
        // Every limit code, latched; pass c=8 repeats code 1 with self-clearing recovery
        for (int s = 0; s < 2; s++)
            for (int c = 1; c < 9; c++)
            begin
                k = (c == 8) ? 3'h1 : 3'(c);
                thr = s ? mx[k] : mn[k];
                wr(`BVFPC_FLT2_OFS, 32'({k, 1'(c == 8)}) << (s ? 3 : 7));
                hit(3'h1, s ? thr + 16'h1 : thr - 16'h1);
                `CHK(s ? o_overvoltage_fault : o_undervoltage_fault, 1'b1)
                `CHK({o_motor_run_allow, o_fault_indicator_n}, 2'b00)
                hit(3'h1, thr); `CHK(s ? o_overvoltage_fault : o_undervoltage_fault, 1'(c != 8))
                hit(3'h2, 16'h0); hit(3'h1, thr); `CHK(s ? o_overvoltage_fault : o_undervoltage_fault, 1'b0)
            end
        // Retry limits: code 0 never stops, others stop on the attempt after the limit
        for (int c = 0; c < 8; c++)
        begin
            hit(3'h2, 16'h0);
            wr(`BVFPC_FLT2_OFS, 32'(c));
            repeat ((c != 0) ? lim[c] : 5'h19) hit(3'h4, 16'h0);
            `CHK(o_retry_allowed, 1'b1)
            if (c != 0)
            begin
                hit(3'h4, 16'h0); `CHK({o_retry_allowed, o_fault_indicator_n}, 2'h0)
                // Run permission follows the latched exhaustion one cycle later
                wt(0); `CHK(o_motor_run_allow, 1'b0)
            end
        end
        rd(`BVFPC_STAT_OFS, q); `CHK(q[8:0], 9'h0ac)
        hit(3'h2, 16'h0); `CHK(o_retry_allowed, 1'b1)
        // Idle feedback level: every code with both base levels
        for (int c = 0; c < 8; c++)
        begin
            set({3'b100 | 3'(c[2]), 2'b00});
            wr(`BVFPC_PIN_OFS, 32'h0800_0000 | (32'(c[1:0]) << 9)); wt(3);
            `CHK(o_speed_feedback_output, (c[1:0] == 2'h0) ? c[2] : 1'(c[1:0] != 2'h2))
        end
        // Fault feedback: code 0 keeps the level seen while running
        set(5'b00100); wr(`BVFPC_PIN_OFS, 32'h0800_0000); wt(3);
        set(5'b01000); wt(3); `CHK(o_speed_feedback_output, 1'b1)
        for (int c = 2; c < 8; c++)
        begin
            set({2'b01, 1'(c[0]), 2'b00});
            wr(`BVFPC_PIN_OFS, 32'h0800_0000 | (32'(c[2:1]) << 7)); wt(3);
            `CHK(o_speed_feedback_output, (c[2:1] == 2'h3) ? c[0] : 1'(c[2:1] == 2'h1))
        end
        set(5'b00010);
        for (int c = 0; c < 2; c++)
        begin
            wr(`BVFPC_PIN_OFS, 32'(c) << 6); wt(3); `CHK(o_alarm_out, 1'(c))
        end
        for (int i = 0; i < 7; i++)
        begin
            set(5'(bt[i][5]));
            wr(`BVFPC_PIN_OFS, (32'(bt[i][4:3]) * 32'h5) | (32'(bt[i][2]) * 32'h30)); wt(8);
            `CHK({o_brake_lowside, o_brake_align}, bt[i][1:0])
            `CHK({o_align_use_cfg_angle, o_speed_mode}, {bt[i][2], bt[i][4:3]})
        end
        final_report;
    end

    // Cuts a hang short; the whole run needs well under a thousand cycles
    initial
    begin
        #60000;
        fail_count++;
        final_report;
    end
endmodule

bind bvfpc_top bvfpc_checker bvfpc_checker_i (.*);
`default_nettype wire
